// ---- verilog/spwm_pkg.sv ----
// Shared constants, types and decode functions of the PWM channel.
// Assumes one 125 MHz clock that stands in for the oscillator.
package spwm_pkg;
  // Clock and instruction-cycle figures
  localparam int CLK_NS   = 8;
  localparam int Q_PHASES = 4;

  // Register byte addresses
  localparam logic [7:0] OFS_COUNT = 8'h00;
  localparam logic [7:0] OFS_LIMIT = 8'h04;
  localparam logic [7:0] OFS_TCTL  = 8'h08;
  localparam logic [7:0] OFS_DBUF  = 8'h0c;
  localparam logic [7:0] OFS_DACT  = 8'h10;
  localparam logic [7:0] OFS_CHCTL = 8'h14;
  localparam logic [7:0] OFS_EVFLG = 8'h18;
  localparam logic [7:0] OFS_EVEN  = 8'h1c;
  localparam logic [7:0] OFS_EVPRI = 8'h20;
  localparam logic [7:0] OFS_DIR   = 8'h24;

  // Field positions
  localparam int TCTL_PRE_LSB  = 0;
  localparam int TCTL_RUN      = 2;
  localparam int TCTL_POST_LSB = 3;
  localparam int CH_MODE_LSB   = 0;
  localparam int CH_DLO_LSB    = 4;
  localparam int EV_POST       = 0;

  // Reset values
  localparam logic [7:0] RST_LIMIT = 8'hff;
  localparam logic [7:0] RST_ZERO  = 8'h00;
  localparam logic       RST_DIR   = 1'b1;

  // Prescale selections and channel modes
  localparam logic [1:0] PRE_1    = 2'h0;
  localparam logic [1:0] PRE_4    = 2'h1;
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [1:0] MODE_PWM = 2'h3;

  typedef enum logic [1:0] {
    SPWM_OFF    = 2'h0,
    SPWM_ARMED  = 2'h1,
    SPWM_ACTIVE = 2'h3
  } spwm_state_t;

  // Last oscillator count of one timer increment: 4, 16 or 64 cycles
  function automatic logic [5:0] spwm_pre_term(input logic [1:0] sel);
    if (sel == PRE_1) return 6'h03;
    else if (sel == PRE_4) return 6'h0f;
    else return 6'h3f;
  endfunction

  // Two time-base extension bits: Q phase or top prescaler bits
  function automatic logic [1:0] spwm_ext(input logic [5:0] sub,
                                          input logic [1:0] sel);
    if (sel == PRE_1) return sub[1:0];
    else if (sel == PRE_4) return sub[3:2];
    else return sub[5:4];
  endfunction
endpackage

// ---- verilog/spwm_tb_if.sv ----
// Link between the channel logic and its period timer.
// Assumes both ends run on pclk.
`timescale 1ns/10ps
interface spwm_tb_if;
  logic       run;
  logic [1:0] pre_sel;
  logic [7:0] limit;
  logic       load;
  logic [7:0] load_val;
  logic [7:0] count;
  logic [1:0] ext;
  logic       wrap;
  logic       step;
  modport ctl (output run, pre_sel, limit, load, load_val,
               input  count, ext, wrap, step);
  modport tb  (input  run, pre_sel, limit, load, load_val,
               output count, ext, wrap, step);
endinterface

// ---- verilog/spwm_timebase.sv ----
// Period timer: prescaler, 8-bit count and 2-bit extension.
// Assumes the control side holds run, prescale and limit steady.
`timescale 1ns/10ps
module spwm_timebase
  import spwm_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  spwm_tb_if.tb     tb
);
  logic [5:0] sub_r;
  logic [7:0] cnt_r;
  logic [5:0] term;
  logic [5:0] lo_mask;
  logic       inc;

  // One increment per 4 x prescale oscillator cycles
  assign term = spwm_pre_term(tb.pre_sel);
  assign inc  = tb.run && (sub_r >= term);

  // Sub-count; a late prescale change just ends the current step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sub_r <= 6'h00;
    end else if (inc) begin
      sub_r <= 6'h00;
    end else if (tb.run) begin
      sub_r <= sub_r + 6'h01;
    end
  end

  // Count clears on the increment after it equals the limit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= RST_ZERO;
    end else if (tb.load) begin
      cnt_r <= tb.load_val;
    end else if (inc) begin
      cnt_r <= (cnt_r == tb.limit) ? RST_ZERO : cnt_r + 8'h01;
    end
  end

  // Time base is count with two low extension bits
  assign tb.count = cnt_r;
  assign tb.ext   = spwm_ext(sub_r, tb.pre_sel);
  assign tb.wrap  = inc && (cnt_r == tb.limit);

  // Time base steps at the next edge when the sub-count bits below the
  // extension bits are all ones
  assign lo_mask = term >> 2;
  assign tb.step = tb.run && ((sub_r & lo_mask) == lo_mask);
endmodule

// ---- verilog/spwm_postscale.sv ----
// Period-match postscaler for a slower update event.
// Assumes tick is a one-cycle pulse on pclk.
`timescale 1ns/10ps
module spwm_postscale #(
  parameter int W = 4
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         tick,
  input  wire logic [W-1:0] ratio,
  output logic              event_p
);
  logic [W-1:0] cnt_r;

  // Event every ratio+1 matches; it never touches the PWM period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r   <= '0;
      event_p <= 1'b0;
    end else begin
      event_p <= tick && (cnt_r >= ratio);
      if (tick) begin
        cnt_r <= (cnt_r >= ratio) ? '0 : cnt_r + W'(1);
      end
    end
  end
endmodule

// ---- verilog/spwm_top.sv ----
// Standard PWM channel with its period timer and an APB register file.
// Assumes an APB master on pclk; pwm_out/pwm_oe go to a pad.
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/10ps
module spwm_top
  import spwm_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             pwm_out,
  output logic             pwm_oe,
  output logic             update_tick
);
  spwm_tb_if tbi ();

  logic [7:0]  limit_r;
  logic [7:0]  tctl_r;
  logic [7:0]  dbuf_r;
  logic [7:0]  dact_r;
  logic [1:0]  dlo_r;
  logic [7:0]  chctl_r;
  logic [7:0]  ev_en_r;
  logic [7:0]  ev_pri_r;
  logic        ev_flag_r;
  logic        dir_r;
  spwm_state_t st_r;
  spwm_state_t st_nxt;
  logic        post_ev;
  logic        acc;
  logic        wr_go;
  logic [31:0] rd_mux;
  logic        pwm_mode;
  logic        pwm_wrap;
  logic [9:0]  duty_buf;
  logic [9:0]  duty_act;
  logic [9:0]  tbase;
  logic [9:0]  tbase_inc;
  logic        duty_hit;

  // Address decode of the mapped places, used by the error answer only
  function automatic logic spwm_mapped(input logic [7:0] a);
    if (a == OFS_COUNT || a == OFS_LIMIT || a == OFS_TCTL) return 1'b1;
    else if (a == OFS_DBUF || a == OFS_DACT) return 1'b1;
    else if (a == OFS_CHCTL || a == OFS_EVFLG) return 1'b1;
    else if (a == OFS_EVEN || a == OFS_EVPRI) return 1'b1;
    else if (a == OFS_DIR) return 1'b1;
    else return 1'b0;
  endfunction

  // Write strobe for one register at the completing edge
  function automatic logic spwm_wr(input logic go, input logic [7:0] a,
                                   input logic [7:0] ofs);
    return go && (a == ofs);
  endfunction

  // APB phases: one wait state, write lands when pready is seen
  assign acc   = psel && penable && !pready;
  assign wr_go = psel && penable && pready && pwrite;

  // Duty words and the 10-bit time base
  assign duty_buf = {dbuf_r, chctl_r[CH_DLO_LSB+1:CH_DLO_LSB]};
  assign duty_act = {dact_r, dlo_r};
  assign tbase    = {tbi.count, tbi.ext};
  assign pwm_mode = (chctl_r[CH_MODE_LSB+3:CH_MODE_LSB+2] == MODE_PWM);
  assign pwm_wrap = tbi.wrap && pwm_mode;

  // Look one edge ahead: a match on the present time base would keep
  // the registered pin high one pclk too long
  assign tbase_inc = tbase + 10'h001;
  assign duty_hit  = tbi.step && (tbase_inc == duty_act);

  // Timer drive; software count writes reload the counter
  assign tbi.run      = tctl_r[TCTL_RUN];
  assign tbi.pre_sel  = tctl_r[TCTL_PRE_LSB+1:TCTL_PRE_LSB];
  assign tbi.limit    = limit_r;
  assign tbi.load     = spwm_wr(wr_go, paddr, OFS_COUNT);
  assign tbi.load_val = pwdata[7:0];

  spwm_timebase u_timebase (
    .pclk    (pclk),
    .presetn (presetn),
    .tb      (tbi)
  );

  // Postscaler hangs off period matches only
  spwm_postscale #(
    .W (4)
  ) u_postscale (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tbi.wrap),
    .ratio   (tctl_r[TCTL_POST_LSB+3:TCTL_POST_LSB]),
    .event_p (post_ev)
  );

  // Read mux; reserved bits read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (paddr == OFS_COUNT) begin
      rd_mux[7:0] = tbi.count;
    end else if (paddr == OFS_LIMIT) begin
      rd_mux[7:0] = limit_r;
    end else if (paddr == OFS_TCTL) begin
      rd_mux[6:0] = tctl_r[6:0];
    end else if (paddr == OFS_DBUF) begin
      rd_mux[7:0] = dbuf_r;
    end else if (paddr == OFS_DACT) begin
      rd_mux[7:0] = dact_r;
    end else if (paddr == OFS_CHCTL) begin
      rd_mux[5:0] = chctl_r[5:0];
    end else if (paddr == OFS_EVFLG) begin
      rd_mux[EV_POST] = ev_flag_r;
      rd_mux[3:2]     = st_r;
    end else if (paddr == OFS_EVEN) begin
      rd_mux[7:0] = ev_en_r;
    end else if (paddr == OFS_EVPRI) begin
      rd_mux[7:0] = ev_pri_r;
    end else if (paddr == OFS_DIR) begin
      rd_mux[0] = dir_r;
    end
  end

  // Answer registers: ready pulses once per access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready <= acc;
      if (acc) begin
        pslverr <= !spwm_mapped(paddr);
        prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // Period and timer control, free to change at any time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limit_r <= RST_LIMIT;
      tctl_r  <= RST_ZERO;
    end else begin
      if (spwm_wr(wr_go, paddr, OFS_LIMIT)) begin
        limit_r <= pwdata[7:0];
      end
      if (spwm_wr(wr_go, paddr, OFS_TCTL)) begin
        tctl_r <= {1'b0, pwdata[6:0]};
      end
    end
  end

  // Buffered duty: software may write it whenever it likes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dbuf_r  <= RST_ZERO;
      chctl_r <= RST_ZERO;
    end else begin
      if (spwm_wr(wr_go, paddr, OFS_DBUF)) begin
        dbuf_r <= pwdata[7:0];
      end
      if (spwm_wr(wr_go, paddr, OFS_CHCTL)) begin
        chctl_r <= {2'b00, pwdata[5:0]};
      end
    end
  end

  // Active duty and hidden latch load at a period match in PWM mode; outside PWM mode software
  // may write the active byte instead, which ignores software while PWM runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dact_r <= RST_ZERO;
      dlo_r  <= 2'b00;
    end else if (pwm_wrap) begin
      dact_r <= dbuf_r;
      dlo_r  <= chctl_r[CH_DLO_LSB+1:CH_DLO_LSB];
    end else if (!pwm_mode && spwm_wr(wr_go, paddr, OFS_DACT)) begin
      dact_r <= pwdata[7:0];
    end
  end

  // Event bookkeeping; a new event beats a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_flag_r <= 1'b0;
      ev_en_r   <= RST_ZERO;
      ev_pri_r  <= RST_ZERO;
      dir_r     <= RST_DIR;
    end else begin
      ev_flag_r <= post_ev || (ev_flag_r &&
                   !(spwm_wr(wr_go, paddr, OFS_EVFLG) && pwdata[EV_POST]));
      if (spwm_wr(wr_go, paddr, OFS_EVEN)) begin
        ev_en_r <= pwdata[7:0];
      end
      if (spwm_wr(wr_go, paddr, OFS_EVPRI)) begin
        ev_pri_r <= pwdata[7:0];
      end
      if (spwm_wr(wr_go, paddr, OFS_DIR)) begin
        dir_r <= pwdata[0];
      end
    end
  end

  // Channel state: armed until the first period match in PWM mode
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      SPWM_OFF: begin
        if (pwm_mode) st_nxt = SPWM_ARMED;
      end
      SPWM_ARMED: begin
        if (!pwm_mode) st_nxt = SPWM_OFF;
        else if (tbi.wrap) st_nxt = SPWM_ACTIVE;
      end
      SPWM_ACTIVE: begin
        if (!pwm_mode) st_nxt = SPWM_OFF;
      end
      default: st_nxt = SPWM_OFF;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= SPWM_OFF;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Output latch. Set at the period match (zero duty stays low), clear
  // at the edge where the time base reaches the duty; a duty past the
  // period never matches, so the pin stays high. Off mode holds it low.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_out <= 1'b0;
    end else if (!pwm_mode) begin
      pwm_out <= 1'b0;
    end else if (tbi.wrap) begin
      pwm_out <= (duty_buf != 10'h000);
    end else if (st_r == SPWM_ACTIVE && duty_hit) begin
      pwm_out <= 1'b0;
    end
  end

  // Pad enable is the inverted direction bit; update event is a pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_oe      <= 1'b0;
      update_tick <= 1'b0;
    end else begin
      pwm_oe      <= !dir_r;
      update_tick <= post_ev;
    end
  end

  // Checks of the channel behaviour
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_match;
    pwm_wrap;
  endsequence

  sequence s_gap;
    (!tbi.wrap) [*3];
  endsequence

  a_count_clears: assert property (
    tbi.wrap |=> tbi.count ==
      ($past(tbi.load) ? $past(tbi.load_val) : 8'h00))
    else $error("count not cleared after period match");

  a_pin_set_at_match: assert property (
    s_match ##0 (duty_buf != 10'h000) |=> pwm_out)
    else $error("pin not set at period match");

  a_zero_duty_low: assert property (
    s_match ##0 (duty_buf == 10'h000) |=> !pwm_out)
    else $error("pin set with zero duty");

  a_duty_latched: assert property (
    s_match |=> duty_act == $past(duty_buf))
    else $error("active duty not loaded at period match");

  a_duty_held: assert property (
    !tbi.wrap && pwm_mode && $past(pwm_mode) |=> $stable(duty_act))
    else $error("active duty changed between period matches");

  a_active_ro: assert property (
    pwm_mode && !tbi.wrap && spwm_wr(wr_go, paddr, OFS_DACT)
    |=> $stable(dact_r))
    else $error("active duty written in PWM mode");

  a_duty_match_clr: assert property (
    pwm_mode && !tbi.wrap && st_r == SPWM_ACTIVE && duty_hit
    |=> !pwm_out)
    else $error("pin not cleared at duty match");

  a_high_holds: assert property (
    pwm_out && pwm_mode && !tbi.wrap && !duty_hit |=> pwm_out)
    else $error("pin fell without a duty match");

  a_match_spacing: assert property (tbi.wrap |=> s_gap)
    else $error("period matches closer than four cycles");

  a_off_low: assert property (!pwm_mode |=> !pwm_out)
    else $error("pin high outside PWM mode");

  a_apb_answer: assert property (
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("bus answer not one wait state");
endmodule

// ---- verification/spwm_load_model.sv ----
// External load on the PWM pin: measures high time and period.
// Assumes pwm_out is a registered level on pclk; the load never drives.
`timescale 1ns/10ps
module spwm_load_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        pwm_out,
  input  wire logic        pwm_oe,
  output logic      [15:0] hi_len,
  output logic      [15:0] per_len,
  output logic      [15:0] rises
);
  logic        prev_r;
  logic [15:0] cnt_r;

  // Cycles since the last rising edge; a rise closes one period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_r  <= 1'b0;
      cnt_r   <= 16'h0000;
      hi_len  <= 16'h0000;
      per_len <= 16'h0000;
      rises   <= 16'h0000;
    end else begin
      prev_r <= pwm_out & pwm_oe; // An undriven pad is not a pulse
      if (pwm_out & pwm_oe & !prev_r) begin
        per_len <= cnt_r;
        cnt_r   <= 16'h0001;
        rises   <= rises + 16'h0001;
      end else begin
        cnt_r <= cnt_r + 16'h0001;
        if (!(pwm_out & pwm_oe) && prev_r) begin
          hi_len <= cnt_r;
        end
      end
    end
  end
endmodule

// ---- verification/test_standard_pwm_with_period_timer.sv ----
// Self-checking bench of the PWM channel, driven through APB.
// Assumes the register map and one-wait-state answer of the design.
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin \
  errors++; $display("unexpected %s exp %h got %h", nm, ex, gt); end end
module test_standard_pwm_with_period_timer;
  import spwm_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pwm_out;
  logic        pwm_oe;
  logic        update_tick;
  logic [15:0] hi_len;
  logic [15:0] per_len;
  logic [15:0] rises;
  logic [31:0] q;
  logic        e;
  int          errors;
  int          n_compared;
  int          f;
  int          ticks;

  spwm_top spwm_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pwm_out(pwm_out), .pwm_oe(pwm_oe), .update_tick(update_tick));
  spwm_load_model spwm_load_model_inst (.pclk(pclk), .presetn(presetn),
    .pwm_out(pwm_out), .pwm_oe(pwm_oe), .hi_len(hi_len),
    .per_len(per_len), .rises(rises));

  // Clock at 125 MHz
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic end_of_test();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // One APB transfer; held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    int k;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    q = prdata;
    e = pslverr;
    if (k >= 50) begin
      errors++;
      end_of_test();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk); // Idle cycle so no signal is driven twice at once
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  // Wait for n further rising edges of the pin, bounded
  task automatic wait_rises(input int n);
    logic [15:0] t;
    int          k;
    t = rises + 16'(n);
    k = 0;
    while (rises !== t && k < 4000) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 4000) begin
      errors++;
      end_of_test();
    end
  endtask

  // Pin must hold one level for n cycles
  task automatic hold(input logic v, input int n);
    int bad;
    bad = 0;
    repeat (n) begin
      @(posedge pclk);
      if (pwm_out !== v) bad++;
    end
    `CHK("pin level cycles off", 0, bad)
  endtask

  initial begin
    errors = 0;
    n_compared = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values and an unmapped place
    `CHK("pwm_oe reset", 1'b0, pwm_oe)
    xfer(1'b0, OFS_LIMIT, 32'h0);
    `CHK("limit", 32'h000000ff, q)
    xfer(1'b0, OFS_DIR, 32'h0);
    `CHK("dir", 32'h00000001, q)
    xfer(1'b0, OFS_CHCTL, 32'h0);
    `CHK("chctl", 32'h00000000, q)
    xfer(1'b0, 8'h28, 32'h0);
    `CHK("unmapped err", 1'b1, e)
    `CHK("unmapped data", 32'h00000000, q)
    // Setup in software order: period 3, duty 9
    // Period 3 stays above the duty upper byte 2
    wr(OFS_LIMIT, 32'h00000003);
    wr(OFS_DBUF, 32'h00000002);
    wr(OFS_CHCTL, 32'h00000010);
    wr(OFS_DIR, 32'h00000000);
    wr(OFS_TCTL, 32'h00000004);
    wr(OFS_CHCTL, 32'h0000001c);
    `CHK("pwm_oe", 1'b1, pwm_oe)
    // Every prescale factor: period and high time
    for (int p = 0; p < 3; p++) begin
      f = (p == 0) ? 1 : (p == 1) ? 4 : 16;
      wr(OFS_TCTL, 32'h00000004 | 32'(p));
      wait_rises(3);
      `CHK("period", 16'((3 + 1) * 4 * f), per_len)
      `CHK("high", 16'(9 * f), hi_len)
    end
    // Active duty is read-only in PWM mode and loads only at the period match
    wait_rises(1);
    wr(OFS_DACT, 32'h00000055);
    wr(OFS_DBUF, 32'h00000001);
    xfer(1'b0, OFS_DACT, 32'h0);
    `CHK("dact held", 32'h00000002, q)
    wait_rises(2);
    xfer(1'b0, OFS_DACT, 32'h0);
    `CHK("dact new", 32'h00000001, q)
    `CHK("high new", 16'(5 * 16), hi_len)
    // Zero duty keeps the pin low
    wr(OFS_TCTL, 32'h00000004);
    wr(OFS_DBUF, 32'h00000000);
    wr(OFS_CHCTL, 32'h0000000c);
    repeat (64) @(posedge pclk);
    hold(1'b0, 64);
    // Duty beyond the period keeps the pin high
    wr(OFS_DBUF, 32'h00000005);
    repeat (64) @(posedge pclk);
    hold(1'b1, 64);
    // Postscale ratio 1 paces the tick, not the period
    wr(OFS_DBUF, 32'h00000002);
    wr(OFS_TCTL, 32'h0000000c);
    wait_rises(2);
    ticks = 0;
    repeat (160) begin
      @(posedge pclk);
      if (update_tick === 1'b1) ticks++;
    end
    `CHK("ticks", 5, ticks)
    `CHK("period post", 16'(16), per_len)
    xfer(1'b0, OFS_EVFLG, 32'h0);
    `CHK("event flag", 1'b1, q[EV_POST])
    // A stopped timer keeps a reloaded count
    wr(OFS_TCTL, 32'h00000000);
    wr(OFS_COUNT, 32'h00000002);
    xfer(1'b0, OFS_COUNT, 32'h0);
    `CHK("count reload", 32'h00000002, q)
    // Clearing channel control forces the pin low
    wr(OFS_CHCTL, 32'h00000000);
    hold(1'b0, 64);
    end_of_test();
  end
endmodule
